// file: src/irg_pkg.sv
// Constants shared by the interrupt request gathering block.
package irg_pkg;

	// Sizes of the source and flag sets.
	localparam int SRC_COUNT = 24;
	localparam int SRC_W = 5;
	localparam int FLAG_COUNT = 51;
	localparam int EXT_COUNT = 4;
	localparam int SYNC_STAGES = 3;

	// Widths of the flag groups that are ORed into one source.
	localparam int TIMER_GRP = 3;
	localparam int UART_GRP = 2;
	localparam int ADC_GRP = 3;
	localparam int PCA_GRP = 9;
	localparam int SYS_GRP = 10;
	localparam int DMA_GRP = 3;

	// Source numbers as the vectoring logic presents them.
	localparam logic [SRC_W-1:0] SRC_EXT0 = 5'h00;
	localparam logic [SRC_W-1:0] SRC_T0 = 5'h01;
	localparam logic [SRC_W-1:0] SRC_EXT1 = 5'h02;
	localparam logic [SRC_W-1:0] SRC_T1 = 5'h03;
	localparam logic [SRC_W-1:0] SRC_UART0 = 5'h04;
	localparam logic [SRC_W-1:0] SRC_T2 = 5'h05;
	localparam logic [SRC_W-1:0] SRC_EXT2 = 5'h06;
	localparam logic [SRC_W-1:0] SRC_SPI = 5'h07;
	localparam logic [SRC_W-1:0] SRC_ADC = 5'h08;
	localparam logic [SRC_W-1:0] SRC_PCA = 5'h09;
	localparam logic [SRC_W-1:0] SRC_SYSTEM = 5'h0a;
	localparam logic [SRC_W-1:0] SRC_KEYPAD = 5'h0b;
	localparam logic [SRC_W-1:0] SRC_TWI0 = 5'h0c;
	localparam logic [SRC_W-1:0] SRC_CMP0 = 5'h0d;
	localparam logic [SRC_W-1:0] SRC_UART1 = 5'h0e;
	localparam logic [SRC_W-1:0] SRC_EXT3 = 5'h0f;
	localparam logic [SRC_W-1:0] SRC_T3 = 5'h10;
	localparam logic [SRC_W-1:0] SRC_CMP1 = 5'h11;
	localparam logic [SRC_W-1:0] SRC_DMA = 5'h12;
	localparam logic [SRC_W-1:0] SRC_CMP2 = 5'h13;
	localparam logic [SRC_W-1:0] SRC_UART2 = 5'h14;
	localparam logic [SRC_W-1:0] SRC_T4 = 5'h15;
	localparam logic [SRC_W-1:0] SRC_UART3 = 5'h16;
	localparam logic [SRC_W-1:0] SRC_TWI1 = 5'h17;

	// Positions of the peripheral flags in the flag vector.
	localparam int IDX_T0_OVF = 0;
	localparam int IDX_T1_OVF = 1;
	localparam int IDX_U0_RX = 2;
	localparam int IDX_U0_TX = 3;
	localparam int IDX_T2_OVF = 4;
	localparam int IDX_T2_LOW = 6;
	localparam int IDX_SPI_DONE = 7;
	localparam int IDX_ADC_DONE = 8;
	localparam int IDX_PCA_OVF = 11;
	localparam int IDX_SYS_BASE = 20;
	localparam int IDX_KEYPAD = 30;
	localparam int IDX_TWI0 = 31;
	localparam int IDX_CMP0 = 32;
	localparam int IDX_U1_RX = 33;
	localparam int IDX_T3_OVF = 35;
	localparam int IDX_T3_LOW = 37;
	localparam int IDX_CMP1 = 38;
	localparam int IDX_DMA_DONE = 39;
	localparam int IDX_CMP2 = 42;
	localparam int IDX_U2_RX = 43;
	localparam int IDX_T4_OVF = 45;
	localparam int IDX_T4_LOW = 47;
	localparam int IDX_U3_RX = 48;
	localparam int IDX_TWI1 = 50;

	// Reset values.
	localparam logic [FLAG_COUNT-1:0] FLAG_RESET = '0;
	localparam logic [SRC_COUNT-1:0] SAMPLE_RESET = '0;
	localparam logic PIN_IDLE = 1'b1;

endpackage

// file: src/irg_flag_bank.sv
// Bank of sticky request flags with hardware set, software write and vector clear.
`timescale 1ns/1ps
module irg_flag_bank
	import irg_pkg::*;
#(
	parameter int WIDTH = FLAG_COUNT
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic resetn,
	// Flag controls.
	input wire logic [WIDTH-1:0] hw_set,
	input wire logic [WIDTH-1:0] sw_write_en,
	input wire logic [WIDTH-1:0] sw_write_value,
	input wire logic [WIDTH-1:0] hw_clear,
	// Flag state.
	output logic [WIDTH-1:0] flags
);

	logic [WIDTH-1:0] flags_r;
	logic [WIDTH-1:0] flags_nxt;

	// A bank needs at least one flag.
	if (WIDTH < 1) begin : g_bad_width
		$error("irg_flag_bank needs WIDTH of at least one");
	end

	// Hardware set beats both a software clear and a vector clear.
	always_comb begin
		flags_nxt = hw_set | (sw_write_en & sw_write_value) |
			(~sw_write_en & flags_r & ~hw_clear); // see RULE19 see RULE22
	end

	// Flag storage.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			flags_r <= FLAG_RESET[WIDTH-1:0];
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign flags = flags_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	chk_set_wins: assert property ((|hw_set) |=> ((flags & $past(hw_set)) == $past(hw_set))) // see RULE19
		else $error("hardware set was lost");
	chk_flag_hold: assert property (hw_set == '0 && sw_write_en == '0 && // see RULE22
		hw_clear == '0 |=> flags == $past(flags))
		else $error("flag changed without a cause");

endmodule

// file: src/irg_ext_sense.sv
// Sense logic and request flag for one external interrupt input.
`timescale 1ns/1ps
module irg_ext_sense
	import irg_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic resetn,
	// Pin and configuration.
	input wire logic pin_level,
	input wire logic type_edge,
	input wire logic polarity_high,
	// Software access and vectoring.
	input wire logic sw_write_en,
	input wire logic sw_write_value,
	input wire logic vector_clear,
	// Request flag.
	output logic request_flag
);

	logic [SYNC_STAGES-1:0] sync_r;
	logic [SYNC_STAGES-1:0] sync_nxt;
	logic filt_r;
	logic filt_nxt;
	logic active_r;
	logic active;
	logic edge_seen;
	logic flag_r;
	logic flag_nxt;

	// Pin synchroniser, settled value and sense decode.
	always_comb begin
		sync_nxt = {sync_r[SYNC_STAGES-2:0], pin_level};
		filt_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : filt_r;
		active = polarity_high ? filt_r : ~filt_r; // see RULE21
		edge_seen = active & ~active_r;
		if (type_edge) begin
			flag_nxt = edge_seen | (sw_write_en ? sw_write_value : (flag_r & ~vector_clear)); // see RULE1 see RULE2
		end else begin
			flag_nxt = active | (sw_write_en & sw_write_value); // see RULE1 see RULE3
		end
	end

	// Registers of the sense path.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			sync_r <= {SYNC_STAGES{PIN_IDLE}};
			filt_r <= PIN_IDLE;
			active_r <= 1'b1; // No false edge at release when the polarity bit is high.
			flag_r <= 1'b0;
		end else begin
			sync_r <= sync_nxt;
			filt_r <= filt_nxt;
			active_r <= active;
			flag_r <= flag_nxt;
		end
	end

	assign request_flag = flag_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	chk_edge_vec_clear: assert property ((type_edge && vector_clear && !edge_seen && !sw_write_en)
		|=> !request_flag) // see RULE2
		else $error("edge flag not cleared on vectoring");
	chk_level_follow: assert property ((!type_edge && !sw_write_en) |=> request_flag == $past(active)) // see RULE3
		else $error("level flag does not follow the input");
	chk_pin_reaches: assert property ((!type_edge && !sw_write_en && // see RULE21
		pin_level == polarity_high) [*6] |-> request_flag)
		else $error("steady active pin gave no request");

endmodule

// file: src/irg_gather.sv
// Interrupt request gathering: per-source requests from peripheral and pin flags.
//
// Operation
// RULE1: Each external input is level or edge sensed by its own type bit.
// RULE2: Edge-sensed external flags clear when their source is vectored to.
// RULE3: Level-sensed external flags follow the input level, no vector clear.
// RULE4: DMA request is OR of completion and two DMA timer flags, kept.
// RULE5: Timer 0 and 1 overflow flags request and clear on vectoring.
// RULE6: Serial port 0 request is OR of receive and transmit, both kept.
// RULE7: Serial ports 1 to 3 request from their receive and transmit flags.
// RULE8: Timer 2 ORs overflow, external and split-mode low-byte flags, kept.
// RULE9: Timers 3 and 4 behave as timer 2.
// RULE10: SPI done flag sets on transfer end and stays until software clears.
// RULE11: ADC request ORs done, window and sampling flags, none auto-cleared.
// RULE12: Counter array ORs base overflow and eight module flags, kept.
// RULE13: System request ORs ten system flags and optionally UART0 transmit.
// RULE14: UART0 transmit feeds the system request only while routing enabled.
// RULE15: System flags are set by their own monitors and detectors.
// RULE16: Keypad flag sets on pattern match and is kept on vectoring.
// RULE17: Each two-wire unit flag sets on a new bus state, kept.
// RULE18: Comparator flags set on selected rising, falling or both edges.
// RULE19: Software writes set or clear any flag like hardware would.
// RULE20: Flags are sampled every cycle and polled on the next cycle.
// RULE21: Polarity bit turns low or falling sense into high or rising.
// RULE22: Kept flags stay set until software or their source clears them.
`timescale 1ns/1ps
module irg_gather
	import irg_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic resetn,
	// External interrupt pins, active low unless polarity is high.
	input wire logic ext0_pin_n,
	input wire logic ext1_pin_n,
	input wire logic ext2_pin_n,
	input wire logic ext3_pin_n,
	// External interrupt type bits, high for edge sense.
	input wire logic ext0_type_select,
	input wire logic ext1_type_select,
	input wire logic ext2_type_select,
	input wire logic ext3_type_select,
	// External interrupt polarity bits.
	input wire logic ext0_polarity_high,
	input wire logic ext1_polarity_high,
	input wire logic ext2_polarity_high,
	input wire logic ext3_polarity_high,
	// Software writes of the external flags.
	input wire logic [EXT_COUNT-1:0] ext_write_en,
	input wire logic [EXT_COUNT-1:0] ext_write_value,
	// Peripheral set pulses for the flag vector.
	input wire logic [FLAG_COUNT-1:0] flag_set_event,
	// Split mode of timers 2, 3 and 4.
	input wire logic timer2_split_mode,
	input wire logic timer3_split_mode,
	input wire logic timer4_split_mode,
	// Comparator outputs and their edge selects.
	input wire logic comparator0_output,
	input wire logic comparator1_output,
	input wire logic comparator2_output,
	input wire logic [1:0] comparator0_edge_select,
	input wire logic [1:0] comparator1_edge_select,
	input wire logic [1:0] comparator2_edge_select,
	// Routing of the UART0 transmit flag to the system source.
	input wire logic tx_to_system_route_enable,
	// Software writes of the flag vector.
	input wire logic [FLAG_COUNT-1:0] flag_write_en,
	input wire logic [FLAG_COUNT-1:0] flag_write_value,
	// Vectoring from the core.
	input wire logic vector_take,
	input wire logic [SRC_W-1:0] vector_source,
	// External request flags.
	output logic ext0_request_flag,
	output logic ext1_request_flag,
	output logic ext2_request_flag,
	output logic ext3_request_flag,
	// Flag readback, sampled requests and the polling view.
	output logic [FLAG_COUNT-1:0] flag_state,
	output logic [SRC_COUNT-1:0] source_request,
	output logic poll_pending
);

	logic [EXT_COUNT-1:0] ext_pin;
	logic [EXT_COUNT-1:0] ext_type;
	logic [EXT_COUNT-1:0] ext_pol;
	logic [EXT_COUNT-1:0] ext_vclr;
	logic [EXT_COUNT-1:0] ext_flag;
	logic [FLAG_COUNT-1:0] hw_set;
	logic [FLAG_COUNT-1:0] hw_clear;
	logic [2:0] cmp_now;
	logic [2:0] cmp_prev_r;
	logic [2:0] cmp_prev_nxt;
	logic [SRC_COUNT-1:0] req_now;
	logic [SRC_COUNT-1:0] sample_r;
	logic [SRC_COUNT-1:0] sample_nxt;
	logic sys_tx;

	// True when the core vectors to the given source.
	function automatic logic vec_hit(input logic take, input logic [SRC_W-1:0] src,
		input logic [SRC_W-1:0] who);
		return take && (src == who);
	endfunction

	// Edge detect with bit 0 selecting rising and bit 1 selecting falling.
	function automatic logic cmp_edge(input logic [1:0] sel, input logic now, input logic prev);
		return (sel[0] & now & ~prev) | (sel[1] & ~now & prev);
	endfunction

	// Gather the external pins and their settings.
	assign ext_pin = {ext3_pin_n, ext2_pin_n, ext1_pin_n, ext0_pin_n};
	assign ext_type = {ext3_type_select, ext2_type_select, ext1_type_select, ext0_type_select};
	assign ext_pol = {ext3_polarity_high, ext2_polarity_high, ext1_polarity_high,
		ext0_polarity_high};

	// Vector clear only reaches the edge flag of the vectored source.
	always_comb begin
		ext_vclr[0] = vec_hit(vector_take, vector_source, SRC_EXT0); // see RULE2
		ext_vclr[1] = vec_hit(vector_take, vector_source, SRC_EXT1); // see RULE2
		ext_vclr[2] = vec_hit(vector_take, vector_source, SRC_EXT2); // see RULE2
		ext_vclr[3] = vec_hit(vector_take, vector_source, SRC_EXT3); // see RULE2
	end

	// One sense unit per external input.
	for (genvar i = 0; i < EXT_COUNT; i++) begin : g_ext
		irg_ext_sense u_sense (
			.clock(clock),
			.resetn(resetn),
			.pin_level(ext_pin[i]),
			.type_edge(ext_type[i]),
			.polarity_high(ext_pol[i]),
			.sw_write_en(ext_write_en[i]),
			.sw_write_value(ext_write_value[i]),
			.vector_clear(ext_vclr[i]),
			.request_flag(ext_flag[i])
		);
	end

	assign ext0_request_flag = ext_flag[0];
	assign ext1_request_flag = ext_flag[1];
	assign ext2_request_flag = ext_flag[2];
	assign ext3_request_flag = ext_flag[3];

	// Comparator outputs come from logic on this clock and need no synchroniser.
	assign cmp_now = {comparator2_output, comparator1_output, comparator0_output};

	// Previous comparator levels for edge detection.
	always_comb begin
		cmp_prev_nxt = cmp_now;
	end

	// Reset loads the live levels, so a comparator that is already high
	// gives no false rising edge when reset is released.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			cmp_prev_r <= cmp_prev_nxt;
		end else begin
			cmp_prev_r <= cmp_prev_nxt;
		end
	end

	// Hardware set terms; most come straight from the peripherals.
	always_comb begin
		hw_set = flag_set_event; // see RULE10 see RULE15 see RULE16 see RULE17
		hw_set[IDX_T2_LOW] = flag_set_event[IDX_T2_LOW] & timer2_split_mode; // see RULE8
		hw_set[IDX_T3_LOW] = flag_set_event[IDX_T3_LOW] & timer3_split_mode; // see RULE9
		hw_set[IDX_T4_LOW] = flag_set_event[IDX_T4_LOW] & timer4_split_mode; // see RULE9
		hw_set[IDX_CMP0] = cmp_edge(comparator0_edge_select, cmp_now[0], cmp_prev_r[0]); // see RULE18
		hw_set[IDX_CMP1] = cmp_edge(comparator1_edge_select, cmp_now[1], cmp_prev_r[1]); // see RULE18
		hw_set[IDX_CMP2] = cmp_edge(comparator2_edge_select, cmp_now[2], cmp_prev_r[2]); // see RULE18
	end

	// Only the timer 0 and timer 1 overflow flags clear on vectoring.
	always_comb begin
		hw_clear = '0; // see RULE4 see RULE6 see RULE7 see RULE11 see RULE12 see RULE13
		hw_clear[IDX_T0_OVF] = vec_hit(vector_take, vector_source, SRC_T0); // see RULE5
		hw_clear[IDX_T1_OVF] = vec_hit(vector_take, vector_source, SRC_T1); // see RULE5
	end

	// Storage for every peripheral flag.
	irg_flag_bank #(
		.WIDTH(FLAG_COUNT)
	) u_bank (
		.clock(clock),
		.resetn(resetn),
		.hw_set(hw_set),
		.sw_write_en(flag_write_en),
		.sw_write_value(flag_write_value),
		.hw_clear(hw_clear),
		.flags(flag_state)
	);

	// The transmit flag joins the system source only while routed.
	assign sys_tx = flag_state[IDX_U0_TX] & tx_to_system_route_enable; // see RULE14

	// Per-source request terms.
	always_comb begin
		req_now = '0;
		req_now[SRC_EXT0] = ext_flag[0];
		req_now[SRC_T0] = flag_state[IDX_T0_OVF]; // see RULE5
		req_now[SRC_EXT1] = ext_flag[1];
		req_now[SRC_T1] = flag_state[IDX_T1_OVF]; // see RULE5
		req_now[SRC_UART0] = |flag_state[IDX_U0_RX +: UART_GRP]; // see RULE6
		req_now[SRC_T2] = |flag_state[IDX_T2_OVF +: TIMER_GRP]; // see RULE8
		req_now[SRC_EXT2] = ext_flag[2];
		req_now[SRC_SPI] = flag_state[IDX_SPI_DONE]; // see RULE10
		req_now[SRC_ADC] = |flag_state[IDX_ADC_DONE +: ADC_GRP]; // see RULE11
		req_now[SRC_PCA] = |flag_state[IDX_PCA_OVF +: PCA_GRP]; // see RULE12
		req_now[SRC_SYSTEM] = (|flag_state[IDX_SYS_BASE +: SYS_GRP]) | sys_tx; // see RULE13
		req_now[SRC_KEYPAD] = flag_state[IDX_KEYPAD]; // see RULE16
		req_now[SRC_TWI0] = flag_state[IDX_TWI0]; // see RULE17
		req_now[SRC_CMP0] = flag_state[IDX_CMP0]; // see RULE18
		req_now[SRC_UART1] = |flag_state[IDX_U1_RX +: UART_GRP]; // see RULE7
		req_now[SRC_EXT3] = ext_flag[3];
		req_now[SRC_T3] = |flag_state[IDX_T3_OVF +: TIMER_GRP]; // see RULE9
		req_now[SRC_CMP1] = flag_state[IDX_CMP1]; // see RULE18
		req_now[SRC_DMA] = |flag_state[IDX_DMA_DONE +: DMA_GRP]; // see RULE4
		req_now[SRC_CMP2] = flag_state[IDX_CMP2]; // see RULE18
		req_now[SRC_UART2] = |flag_state[IDX_U2_RX +: UART_GRP]; // see RULE7
		req_now[SRC_T4] = |flag_state[IDX_T4_OVF +: TIMER_GRP]; // see RULE9
		req_now[SRC_UART3] = |flag_state[IDX_U3_RX +: UART_GRP]; // see RULE7
		req_now[SRC_TWI1] = flag_state[IDX_TWI1]; // see RULE17
	end

	// Sample every cycle; the core polls the sample in the next cycle.
	always_comb begin
		sample_nxt = req_now; // see RULE20
	end

	// Sample register that the core polls; it holds no request during reset.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			sample_r <= SAMPLE_RESET;
		end else begin
			sample_r <= sample_nxt;
		end
	end

	// The sampled requests and their OR, which the core reads in its polling cycle.
	assign source_request = sample_r;
	assign poll_pending = |sample_r; // see RULE20

	// All checks run on the system clock and rest while reset is applied.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// A timer 0 vector with no competing set or write.
	sequence s_t0_vector;
		vector_take && vector_source == SRC_T0 && !flag_set_event[IDX_T0_OVF] &&
			!flag_write_en[IDX_T0_OVF];
	endsequence

	// A serial port 0 vector while its receive flag is pending.
	sequence s_u0_vector;
		vector_take && vector_source == SRC_UART0 && flag_state[IDX_U0_RX] &&
			!flag_write_en[IDX_U0_RX];
	endsequence

	// Flag state that stays quiet for the system source.
	sequence s_sys_quiet;
		!tx_to_system_route_enable && flag_state[IDX_SYS_BASE +: SYS_GRP] == '0;
	endsequence

	// A timer 1 vector with no competing set or write.
	sequence s_t1_vector;
		vector_take && vector_source == SRC_T1 && !flag_set_event[IDX_T1_OVF] &&
			!flag_write_en[IDX_T1_OVF];
	endsequence

	// A timer 2 low-byte overflow while the timer runs unsplit.
	sequence s_t2_unsplit_low;
		!timer2_split_mode && flag_set_event[IDX_T2_LOW] && !flag_state[IDX_T2_LOW] &&
			!flag_write_en[IDX_T2_LOW];
	endsequence

	chk_timer0_vec_clear: assert property (s_t0_vector |=> !flag_state[IDX_T0_OVF]) // see RULE5
		else $error("timer 0 flag kept after vectoring");
	chk_uart0_kept: assert property (s_u0_vector |=> flag_state[IDX_U0_RX]) // see RULE6
		else $error("uart 0 receive flag cleared by vectoring");
	chk_sample_lag: assert property (1'b1 |=> source_request == $past(req_now)) // see RULE20
		else $error("sample does not lag the request by one cycle");
	chk_route_gate: assert property (s_sys_quiet |=> !source_request[SRC_SYSTEM]) // see RULE14
		else $error("system request without a routed flag");
	chk_dma_request: assert property ((|flag_state[IDX_DMA_DONE +: DMA_GRP]) |=> // see RULE4
		source_request[SRC_DMA])
		else $error("dma flag gave no dma request");
	chk_cmp_rise: assert property ((comparator0_edge_select[0] && // see RULE18
		comparator0_output && !cmp_prev_r[0]) |=> flag_state[IDX_CMP0] ##1
		source_request[SRC_CMP0])
		else $error("comparator 0 rising edge missed");
	chk_timer1_vec_clear: assert property (s_t1_vector |=> !flag_state[IDX_T1_OVF]) // see RULE5
		else $error("timer 1 flag kept after vectoring");
	chk_split_gate: assert property (s_t2_unsplit_low |=> !flag_state[IDX_T2_LOW]) // see RULE8
		else $error("low byte flag set outside split mode");
	chk_route_open: assert property ((tx_to_system_route_enable && flag_state[IDX_U0_TX]) |=> // see RULE14
		source_request[SRC_SYSTEM])
		else $error("routed transmit flag gave no system request");
	chk_ext_request: assert property (ext0_request_flag |=> source_request[SRC_EXT0]) // see RULE1
		else $error("external flag gave no request");
	chk_kept_flags: assert property (1'b1 |=> // see RULE22
		($past(flag_state[FLAG_COUNT-1:2]) & ~flag_state[FLAG_COUNT-1:2] &
		~$past(flag_write_en[FLAG_COUNT-1:2])) == '0)
		else $error("kept flag cleared without a software write");

endmodule

// file: testbench/irg_core_model.sv
// Behavioural model of the core's vectoring logic facing the gathering block.
`timescale 1ns/1ps
module irg_core_model
	import irg_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic resetn,
	// Commands from the bench and the polled requests.
	input wire logic cmd_valid,
	input wire logic [SRC_W-1:0] cmd_source,
	input wire logic [SRC_COUNT-1:0] source_request,
	// Vectoring towards the block.
	output logic vector_take,
	output logic [SRC_W-1:0] vector_source
);
	// Vectors only to a polled, pending source; between vectors the number scrambles.
	always @(posedge clock) begin
		if (!resetn) begin
			vector_take <= 1'b0;
			vector_source <= 5'h00;
		end else if (cmd_valid && source_request[cmd_source]) begin
			vector_take <= 1'b1;
			vector_source <= cmd_source;
		end else begin
			vector_take <= 1'b0;
			vector_source <= ~vector_source;
		end
	end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the interrupt request gathering block.
`timescale 1ns/1ps
module testbench
	import irg_pkg::*;
;
	logic clock, resetn, route, cmd_valid, vector_take, poll_pending;
	logic [3:0] ext_pin, ext_type, ext_pol, ext_wen, ext_wval, ext_flag;
	logic [FLAG_COUNT-1:0] set_ev, wen, wval, flag_state;
	logic [2:0] split, cmp_out;
	logic [1:0] cmp_sel [3];
	logic [SRC_W-1:0] cmd_src, vector_source;
	logic [SRC_COUNT-1:0] source_request;
	int n_fail, checked, cycles;
	int cmp_idx [3] = '{IDX_CMP0, IDX_CMP1, IDX_CMP2};
	int low_idx [3] = '{IDX_T2_LOW, IDX_T3_LOW, IDX_T4_LOW};
	logic [SRC_W-1:0] ext_src [4] = '{SRC_EXT0, SRC_EXT1, SRC_EXT2, SRC_EXT3};

	// The clock toggles every half period of 2.5 ns.
	always #2.5 clock = ~clock;

	irg_gather u_dut (.clock(clock), .resetn(resetn),
		.ext0_pin_n(ext_pin[0]), .ext1_pin_n(ext_pin[1]), .ext2_pin_n(ext_pin[2]),
		.ext3_pin_n(ext_pin[3]), .ext0_type_select(ext_type[0]),
		.ext1_type_select(ext_type[1]), .ext2_type_select(ext_type[2]),
		.ext3_type_select(ext_type[3]), .ext0_polarity_high(ext_pol[0]),
		.ext1_polarity_high(ext_pol[1]), .ext2_polarity_high(ext_pol[2]),
		.ext3_polarity_high(ext_pol[3]), .ext_write_en(ext_wen), .ext_write_value(ext_wval),
		.flag_set_event(set_ev), .timer2_split_mode(split[0]), .timer3_split_mode(split[1]),
		.timer4_split_mode(split[2]), .comparator0_output(cmp_out[0]),
		.comparator1_output(cmp_out[1]), .comparator2_output(cmp_out[2]),
		.comparator0_edge_select(cmp_sel[0]), .comparator1_edge_select(cmp_sel[1]),
		.comparator2_edge_select(cmp_sel[2]), .tx_to_system_route_enable(route),
		.flag_write_en(wen), .flag_write_value(wval), .vector_take(vector_take),
		.vector_source(vector_source), .ext0_request_flag(ext_flag[0]),
		.ext1_request_flag(ext_flag[1]), .ext2_request_flag(ext_flag[2]),
		.ext3_request_flag(ext_flag[3]), .flag_state(flag_state),
		.source_request(source_request), .poll_pending(poll_pending));

	irg_core_model u_core (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid),
		.cmd_source(cmd_src), .source_request(source_request),
		.vector_take(vector_take), .vector_source(vector_source));

	// Source that each flag position feeds, from the source table.
	function automatic logic [SRC_W-1:0] src_of(input int i);
		case (i) inside
			0: return SRC_T0;
			1: return SRC_T1;
			[2:3]: return SRC_UART0;
			[4:6]: return SRC_T2;
			7: return SRC_SPI;
			[8:10]: return SRC_ADC;
			[11:19]: return SRC_PCA;
			[20:29]: return SRC_SYSTEM;
			30: return SRC_KEYPAD;
			31: return SRC_TWI0;
			32: return SRC_CMP0;
			[33:34]: return SRC_UART1;
			[35:37]: return SRC_T3;
			38: return SRC_CMP1;
			[39:41]: return SRC_DMA;
			42: return SRC_CMP2;
			[43:44]: return SRC_UART2;
			[45:47]: return SRC_T4;
			[48:49]: return SRC_UART3;
			default: return SRC_TWI1;
		endcase
	endfunction

	// Compares a value seen with its expectation and counts the outcome.
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Waits n edges, then lets that edge's updates land.
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// One-cycle peripheral set pulse; the flag is visible when the task returns.
	task automatic pulse_set(input int i);
		@(posedge clock);
		set_ev[i] <= 1'b1;
		@(posedge clock);
		set_ev[i] <= 1'b0;
		#1;
	endtask

	// One-cycle software write of a vector flag, or of an external flag when ext is set.
	task automatic wr(input bit ext, input int i, input logic v);
		@(posedge clock);
		if (ext) begin
			ext_wen[i] <= 1'b1;
			ext_wval[i] <= v;
		end else begin
			wen[i] <= 1'b1;
			wval[i] <= v;
		end
		@(posedge clock);
		ext_wen <= 4'h0;
		wen <= '0;
		tick(1);
	endtask

	// Asks the core model to vector, then waits until flag and sample have settled.
	task automatic vec(input logic [SRC_W-1:0] s);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_src <= s;
		@(posedge clock);
		cmd_valid <= 1'b0;
		tick(3);
	endtask

	// Closing report, reached from the main sequence or the cycle ceiling.
	task automatic give_verdict();
		if (n_fail == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the length of the sequence.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			give_verdict();
		end
	end

	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		{ext_pin, ext_type, ext_pol, ext_wen, ext_wval} = {4'hf, 16'h0000};
		{set_ev, wen, wval} = '0;
		{split, cmp_out, route, cmd_valid, cmd_src} = {3'h7, 3'h0, 2'h0, 5'h00};
		cmp_sel = '{2'h1, 2'h1, 2'h1};
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		tick(2);
		chk("flags after reset", flag_state, 64'h0000);
		chk("poll after reset", poll_pending, 0);
		// Every peripheral flag except the comparator flags: set, request, vector, then software clear.
		for (int i = 0; i < FLAG_COUNT; i++) begin
			if (i == IDX_CMP0 || i == IDX_CMP1 || i == IDX_CMP2) continue;
			pulse_set(i);
			chk($sformatf("flag %0d", i), flag_state[i], 1);
			tick(1);
			chk($sformatf("request %0d", i), source_request[src_of(i)], 1);
			chk("poll", poll_pending, 1);
			if (i == IDX_U0_TX) chk("system unrouted", source_request[SRC_SYSTEM], 0);
			vec(src_of(i));
			chk($sformatf("kept %0d", i), flag_state[i], i > 1);
			wr(0, i, 1'b0);
			tick(1);
			chk($sformatf("cleared %0d", i), source_request[src_of(i)], 0);
		end
		// Routed transmit flag feeds the system source and survives vectoring.
		@(posedge clock);
		route <= 1'b1;
		pulse_set(IDX_U0_TX);
		vec(SRC_SYSTEM);
		chk("system routed", source_request[SRC_SYSTEM], 1);
		wr(0, IDX_U0_TX, 1'b0);
		// Low-byte flags only set in split mode; software set raises a request.
		@(posedge clock);
		split <= 3'h0;
		for (int t = 0; t < 3; t++) begin
			pulse_set(low_idx[t]);
			chk("low byte unsplit", flag_state[low_idx[t]], 0);
		end
		wr(0, IDX_KEYPAD, 1'b1);
		tick(1);
		chk("software set", source_request[SRC_KEYPAD], 1);
		wr(0, IDX_KEYPAD, 1'b0);
		// Comparators: rising select, falling select, then both edges.
		for (int c = 0; c < 3; c++) begin
			@(posedge clock);
			cmp_out[c] <= 1'b1;
			tick(3);
			chk("cmp rise", flag_state[cmp_idx[c]], 1);
			chk("cmp req", source_request[src_of(cmp_idx[c])], 1);
			wr(0, cmp_idx[c], 1'b0);
			@(posedge clock);
			cmp_sel[c] <= 2'h2;
			cmp_out[c] <= 1'b0;
			tick(3);
			chk("cmp fall", flag_state[cmp_idx[c]], 1);
			wr(0, cmp_idx[c], 1'b0);
			@(posedge clock);
			cmp_sel[c] <= 2'h3;
			cmp_out[c] <= 1'b1;
			tick(3);
			chk("cmp both", flag_state[cmp_idx[c]], 1);
			wr(0, cmp_idx[c], 1'b0);
		end
		// External inputs: level, falling edge, then rising edge with polarity high.
		for (int e = 0; e < 4; e++) begin
			@(posedge clock);
			ext_pin[e] <= 1'b0;
			tick(8);
			chk("level set", ext_flag[e], 1);
			vec(ext_src[e]);
			chk("level kept", ext_flag[e], 1);
			@(posedge clock);
			ext_pin[e] <= 1'b1;
			tick(8);
			chk("level drop", ext_flag[e], 0);
			@(posedge clock);
			ext_type[e] <= 1'b1;
			ext_pin[e] <= 1'b0;
			tick(8);
			@(posedge clock);
			ext_pin[e] <= 1'b1;
			tick(8);
			chk("edge set", ext_flag[e], 1);
			vec(ext_src[e]);
			chk("edge vector clear", ext_flag[e], 0);
			@(posedge clock);
			ext_pol[e] <= 1'b1;
			ext_pin[e] <= 1'b0;
			tick(8);
			wr(1, e, 1'b0);
			tick(8);
			chk("rise idle", ext_flag[e], 0);
			@(posedge clock);
			ext_pin[e] <= 1'b1;
			tick(8);
			chk("rise set", ext_flag[e], 1);
			wr(1, e, 1'b0);
			chk("software clear", ext_flag[e], 0);
		end
		give_verdict();
	end
endmodule
